/* rtl/spimsc_pkg.sv */
package spimsc_pkg;
    localparam logic [31:0] ADDR_CTRL1 = 32'h40013000;
    localparam logic [31:0] ADDR_CTRL2 = 32'h40013004;
    localparam logic [31:0] ADDR_STAT = 32'h40013008;
    localparam logic [31:0] ADDR_DATA = 32'h4001300c;
    localparam logic [31:0] ADDR_POLY = 32'h40013010;
    localparam logic [31:0] ADDR_RXCRC = 32'h40013014;
    localparam logic [31:0] ADDR_TXCRC = 32'h40013018;
    localparam logic [31:0] ADDR_HSCTL = 32'h40013024;

    localparam logic [15:0] RST_CTRL1 = 16'h0000;
    localparam logic [15:0] RST_CTRL2 = 16'h0000;
    localparam logic [15:0] RST_POLY = 16'h0007;
    localparam logic [15:0] RST_HSCTL = 16'h0000;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] MASK_CTRL2 = 16'h00e7;
    localparam logic [15:0] MASK_HSCTL = 16'h0001;
    localparam logic [15:0] MASK_BYTE = 16'h00ff;

    // Control one fields
    localparam int C1_SWM = 15;
    localparam int C1_SWDIR = 14;
    localparam int C1_CHECKSUM_ENABLE = 13;
    localparam int C1_SEND_CHECKSUM_NEXT = 12;
    localparam int C1_DFF = 11;
    localparam int C1_RECEIVE_ONLY_MODE = 10;
    localparam int C1_SSM = 9;
    localparam int C1_SSI = 8;
    localparam int C1_LSB = 7;
    localparam int C1_EN = 6;
    localparam int C1_BR = 3;
    localparam int C1_MASTER_SELECT = 2;
    localparam int C1_CLOCK_IDLE_POLARITY = 1;
    localparam int C1_CLOCK_SAMPLE_PHASE = 0;
    // Control two fields
    localparam int C2_TRANSMIT_EMPTY_IRQ_EN = 7;
    localparam int C2_RECEIVE_FULL_IRQ_EN = 6;
    localparam int C2_ERROR_IRQ_EN = 5;
    localparam int C2_SELECT_OUTPUT_ENABLE = 2;
    localparam int C2_TXDMA = 1;
    localparam int C2_RXDMA = 0;
    // Status fields, then the HSCTL receive enable field
    localparam int ST_BSY = 7;
    localparam int ST_OVR = 6;
    localparam int ST_MODE_FAULT_FLAG = 5;
    localparam int ST_CHECKSUM_ERROR_FLAG = 4;
    localparam int ST_TXE = 1;
    localparam int ST_RECEIVE_FULL_FLAG = 0;
    localparam int HS_RXEN = 0;

    localparam logic [4:0] BITS_BYTE = 5'h08;
    localparam logic [4:0] BITS_HALF = 5'h10;
    localparam logic [8:0] DIV_BASE = 9'h002;
    localparam logic [8:0] DIV_HS_ADD = 9'h002;

    typedef enum logic [1:0] {
        SPIMSC_IDLE = 2'b00,
        SPIMSC_MASTER = 2'b01,
        SPIMSC_SLAVE = 2'b10
    } spimsc_state_t;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic nss;
    } spimsc_pins_t;
endpackage

/* rtl/spimsc_controller.sv */
// Design decision made here: register access over APB.
`timescale 1ns/1ns
module spimsc_controller (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic PREADY,
    output logic [31:0] PRDATA,
    output logic PSLVERR,
    input wire spimsc_pkg::spimsc_pins_t PIN_IN,
    output spimsc_pkg::spimsc_pins_t PIN_OUT,
    output spimsc_pkg::spimsc_pins_t PIN_OE,
    output logic IRQ,
    output logic TX_DMA_REQ,
    output logic RX_DMA_REQ
);
    import spimsc_pkg::*;

    logic [15:0] ctrl1, ctrl2, hsctl, poly, tx_buf, rx_buf, tx_shift, rx_shift, tx_crc, rx_crc;
    logic [15:0] next_ctrl1, status;
    logic transmit_empty_flag, receive_full_flag, overrun_flag, mode_fault_flag, checksum_error_flag, mode_fault_flag_armed, ovr_armed, crc_follow, crc_word, sck_prev;
    logic [8:0] clk_cnt;
    logic [4:0] bit_cnt;
    spimsc_state_t state, next_state;

    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic b,
                                             input logic [15:0] p, input logic wide);
        logic fb;
        logic [15:0] n;
        fb = b ^ (wide ? crc[15] : crc[7]);
        n = {crc[14:0], 1'b0} ^ (fb ? p : RST_WORD);
        crc_step = wide ? n : (n & MASK_BYTE);
    endfunction

    // Bus decode
    wire setup = PSEL & ~PENABLE;
    wire access = PSEL & PENABLE & PREADY;
    wire wr = access & PWRITE;
    wire rd = access & ~PWRITE;
    wire hit_c1 = PADDR == ADDR_CTRL1;
    wire hit_c2 = PADDR == ADDR_CTRL2;
    wire hit_st = PADDR == ADDR_STAT;
    wire hit_data = PADDR == ADDR_DATA;
    wire hit_poly = PADDR == ADDR_POLY;
    wire hit_rxcrc = PADDR == ADDR_RXCRC;
    wire hit_txcrc = PADDR == ADDR_TXCRC;
    wire hit_hs = PADDR == ADDR_HSCTL;
    wire mapped = hit_c1 | hit_c2 | hit_st | hit_data | hit_poly | hit_rxcrc | hit_txcrc | hit_hs;

    // Control fields
    wire swm = ctrl1[C1_SWM];
    wire swdir = ctrl1[C1_SWDIR];
    wire checksum_enable = ctrl1[C1_CHECKSUM_ENABLE];
    wire send_checksum_next = ctrl1[C1_SEND_CHECKSUM_NEXT];
    wire dff = ctrl1[C1_DFF];
    wire receive_only_mode = ctrl1[C1_RECEIVE_ONLY_MODE];
    wire soft_select_manage = ctrl1[C1_SSM];
    wire soft_select_level = ctrl1[C1_SSI];
    wire lsb_first = ctrl1[C1_LSB];
    wire port_en = ctrl1[C1_EN];
    wire [2:0] br = ctrl1[C1_BR +: 3];
    wire master = ctrl1[C1_MASTER_SELECT];
    wire clock_idle_polarity = ctrl1[C1_CLOCK_IDLE_POLARITY];
    wire clock_sample_phase = ctrl1[C1_CLOCK_SAMPLE_PHASE];
    wire select_output_enable = ctrl2[C2_SELECT_OUTPUT_ENABLE];
    wire hsrx = hsctl[HS_RXEN];

    wire [4:0] nbits = dff ? BITS_HALF : BITS_BYTE;
    wire [3:0] msb_idx = 4'(nbits - 5'h01);
    // Minimum divide is two, so the serial clock never passes half the bus clock
    wire [8:0] div = hsrx ? (9'(br) + DIV_HS_ADD) : (DIV_BASE << br);
    wire [8:0] half = div >> 1;

    wire nss_int = soft_select_manage ? soft_select_level : PIN_IN.nss;
    wire nss_self = select_output_enable & ~soft_select_manage & PIN_OE.nss;
    // Select low while we are not the one pulling it means another master
    wire fault = port_en & master & ~nss_int & ~nss_self;
    wire rx_only_m = receive_only_mode | (swm & ~swdir);
    wire tx_allowed = ~receive_only_mode & (~swm | swdir);
    wire selected = port_en & ~master & ~nss_int;

    // Clock edges: master from its divider, slave from the pin
    wire m_lead = (state == SPIMSC_MASTER) & (clk_cnt == half - 9'h001);
    wire m_trail = (state == SPIMSC_MASTER) & (clk_cnt == div - 9'h001);
    wire s_lead = (state == SPIMSC_SLAVE) & (sck_prev == clock_idle_polarity) & (PIN_IN.sck != clock_idle_polarity);
    wire s_trail = (state == SPIMSC_SLAVE) & (sck_prev != clock_idle_polarity) & (PIN_IN.sck == clock_idle_polarity);
    wire lead = m_lead | s_lead;
    wire trail = m_trail | s_trail;
    wire sample = clock_sample_phase ? trail : lead;
    wire last = clock_sample_phase ? (bit_cnt == nbits - 5'h01) : (bit_cnt == nbits);
    wire word_end = trail & last;
    // First bit must already stand on the wire, so the first shift is skipped
    wire shift = clock_sample_phase ? (lead & (bit_cnt != 5'h00)) : (trail & ~last);
    wire rx_done = sample & (bit_cnt == nbits - 5'h01);

    wire in_bit = master ? (swm ? PIN_IN.mosi : PIN_IN.miso) : (swm ? PIN_IN.miso : PIN_IN.mosi);
    wire m_more = ~transmit_empty_flag | rx_only_m | crc_follow;
    wire m_start = (state == SPIMSC_IDLE) & port_en & master & ~fault & m_more;
    wire s_start = (state == SPIMSC_IDLE) & selected;
    wire load = m_start | s_start | (word_end & ((state == SPIMSC_SLAVE) | m_more));
    wire load_buf = load & ~crc_follow & ~transmit_empty_flag;
    // Checksum next values come first: the load mux hands out the transmit one
    wire crc_clear = wr & hit_c1 & PWDATA[C1_CHECKSUM_ENABLE] & ~checksum_enable & ~port_en;
    wire crc_upd = checksum_enable & sample & ~crc_word & (state != SPIMSC_IDLE);
    wire [15:0] next_tx_crc = crc_upd ? crc_step(tx_crc, PIN_OUT.mosi | PIN_OUT.miso, poly, dff)
                                      : tx_crc;
    wire [15:0] next_rx_crc = crc_upd ? crc_step(rx_crc, in_bit, poly, dff) : rx_crc;
    wire [15:0] load_val = crc_follow ? next_tx_crc : (transmit_empty_flag ? RST_WORD : tx_buf);

    wire [15:0] next_tx_shift = load ? load_val :
        shift ? (lsb_first ? {1'b0, tx_shift[15:1]} : {tx_shift[14:0], 1'b0}) : tx_shift;
    wire next_out = lsb_first ? next_tx_shift[0] : next_tx_shift[msb_idx];
    wire [15:0] next_rx_shift = lsb_first ? {in_bit, rx_shift[15:1]} : {rx_shift[14:0], in_bit};
    wire [15:0] rx_word = dff ? next_rx_shift :
        (lsb_first ? {8'h00, next_rx_shift[15:8]} : (next_rx_shift & MASK_BYTE));

    wire rx_commit = rx_done & (state != SPIMSC_IDLE);
    wire rd_data = rd & hit_data;
    wire crc_bad = rx_commit & crc_word & (rx_word != rx_crc);
    wire busy = (state != SPIMSC_IDLE) | ~transmit_empty_flag;
    wire err_any = overrun_flag | mode_fault_flag | checksum_error_flag;

    always_comb begin
        status = RST_WORD;
        status[ST_BSY] = busy;
        status[ST_OVR] = overrun_flag;
        status[ST_MODE_FAULT_FLAG] = mode_fault_flag;
        status[ST_CHECKSUM_ERROR_FLAG] = checksum_error_flag;
        status[ST_TXE] = transmit_empty_flag;
        status[ST_RECEIVE_FULL_FLAG] = receive_full_flag;
    end

    wire [15:0] rd_mux = hit_c1 ? ctrl1 : hit_c2 ? ctrl2 : hit_st ? status :
        hit_data ? rx_buf : hit_poly ? poly : hit_rxcrc ? rx_crc : hit_txcrc ? tx_crc :
        hit_hs ? hsctl : RST_WORD;

    always_comb begin
        next_ctrl1 = ctrl1;
        if (wr & hit_c1) begin
            next_ctrl1 = PWDATA[15:0];
            // Checksum enable and frame length are frozen while the port runs
            if (port_en) begin
                next_ctrl1[C1_CHECKSUM_ENABLE] = checksum_enable;
                next_ctrl1[C1_DFF] = dff;
            end
        end
        if (load & crc_follow) begin
            next_ctrl1[C1_SEND_CHECKSUM_NEXT] = 1'b0;
        end
        if (fault) begin
            next_ctrl1[C1_EN] = 1'b0;
            next_ctrl1[C1_MASTER_SELECT] = 1'b0;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            SPIMSC_IDLE: begin
                if (m_start) begin
                    next_state = SPIMSC_MASTER;
                end else if (s_start) begin
                    next_state = SPIMSC_SLAVE;
                end
            end
            SPIMSC_MASTER: begin
                if (fault | ~port_en | (word_end & ~m_more)) begin
                    next_state = SPIMSC_IDLE;
                end
            end
            SPIMSC_SLAVE: begin
                if (~selected) begin
                    next_state = SPIMSC_IDLE;
                end
            end
            default: next_state = SPIMSC_IDLE;
        endcase
    end

    // Bus slave: zero wait, answer registered in the setup cycle
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h00000000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= setup;
            PRDATA <= setup & ~PWRITE ? {16'h0000, rd_mux} : 32'h00000000;
            PSLVERR <= setup & ~mapped;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            ctrl1 <= RST_CTRL1;
            ctrl2 <= RST_CTRL2;
            poly <= RST_POLY;
            hsctl <= RST_HSCTL;
            tx_buf <= RST_WORD;
        end else begin
            ctrl1 <= next_ctrl1;
            if (wr & hit_c2) begin
                ctrl2 <= PWDATA[15:0] & MASK_CTRL2;
            end
            if (wr & hit_poly) begin
                poly <= PWDATA[15:0];
            end
            if (wr & hit_hs) begin
                hsctl <= PWDATA[15:0] & MASK_HSCTL;
            end
            if (wr & hit_data) begin
                tx_buf <= dff ? PWDATA[15:0] : (PWDATA[15:0] & MASK_BYTE);
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            state <= SPIMSC_IDLE;
            clk_cnt <= 9'h000;
            bit_cnt <= 5'h00;
            sck_prev <= 1'b0;
            tx_shift <= RST_WORD;
            rx_shift <= RST_WORD;
        end else begin
            state <= next_state;
            sck_prev <= PIN_IN.sck;
            clk_cnt <= (load | m_trail | (state != SPIMSC_MASTER)) ? 9'h000 : clk_cnt + 9'h001;
            if (load | (next_state == SPIMSC_IDLE)) begin
                bit_cnt <= 5'h00;
            end else if (sample) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
            tx_shift <= next_tx_shift;
            if (sample) begin
                rx_shift <= next_rx_shift;
            end
        end
    end

    // Transmit buffer and checksum sequencing
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            transmit_empty_flag <= 1'b1;
            crc_follow <= 1'b0;
            crc_word <= 1'b0;
            tx_crc <= RST_WORD;
            rx_crc <= RST_WORD;
        end else begin
            // New data written in the load cycle is a fresh word, so the write wins
            if (wr & hit_data) begin
                transmit_empty_flag <= 1'b0;
            end else if (load_buf) begin
                transmit_empty_flag <= 1'b1;
            end
            if (load) begin
                crc_follow <= load_buf & send_checksum_next;
                crc_word <= crc_follow;
            end else if (state == SPIMSC_IDLE) begin
                crc_word <= 1'b0;
            end
            tx_crc <= crc_clear ? RST_WORD : next_tx_crc;
            rx_crc <= crc_clear ? RST_WORD : next_rx_crc;
        end
    end

    // Receive buffer and error flags; a set always beats a clear
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            rx_buf <= RST_WORD;
            receive_full_flag <= 1'b0;
            overrun_flag <= 1'b0;
            ovr_armed <= 1'b0;
            mode_fault_flag <= 1'b0;
            mode_fault_flag_armed <= 1'b0;
            checksum_error_flag <= 1'b0;
        end else begin
            if (rx_commit & (~receive_full_flag | rd_data)) begin
                rx_buf <= rx_word;
            end
            receive_full_flag <= (receive_full_flag & ~rd_data) | rx_commit;
            if (rx_commit & receive_full_flag & ~rd_data) begin
                overrun_flag <= 1'b1;
            end else if (rd & hit_st & ovr_armed) begin
                overrun_flag <= 1'b0;
            end
            // Only a data read made while the overrun stands arms its clear
            if (rd_data & overrun_flag) begin
                ovr_armed <= 1'b1;
            end else if (rd & hit_st) begin
                ovr_armed <= 1'b0;
            end
            if (fault) begin
                mode_fault_flag <= 1'b1;
            end else if (wr & hit_c1 & mode_fault_flag_armed) begin
                mode_fault_flag <= 1'b0;
            end
            if ((rd | wr) & hit_st) begin
                mode_fault_flag_armed <= 1'b1;
            end else if (wr & hit_c1) begin
                mode_fault_flag_armed <= 1'b0;
            end
            if (crc_bad) begin
                checksum_error_flag <= 1'b1;
            end else if (wr & hit_st & ~PWDATA[ST_CHECKSUM_ERROR_FLAG]) begin
                checksum_error_flag <= 1'b0;
            end
        end
    end

    // Pins, interrupt and DMA requests
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            PIN_OUT <= '0;
            PIN_OE <= '0;
            IRQ <= 1'b0;
            TX_DMA_REQ <= 1'b0;
            RX_DMA_REQ <= 1'b0;
        end else begin
            if (next_state != SPIMSC_MASTER) begin
                PIN_OUT.sck <= clock_idle_polarity;
            end else if (m_lead) begin
                PIN_OUT.sck <= ~clock_idle_polarity;
            end else if (m_trail) begin
                PIN_OUT.sck <= clock_idle_polarity;
            end
            PIN_OUT.mosi <= next_out;
            PIN_OUT.miso <= next_out;
            PIN_OUT.nss <= 1'b0;
            PIN_OE.sck <= port_en & master;
            PIN_OE.mosi <= port_en & master & tx_allowed;
            PIN_OE.miso <= selected & tx_allowed;
            PIN_OE.nss <= select_output_enable & ~soft_select_manage & (next_state == SPIMSC_MASTER);
            IRQ <= (transmit_empty_flag & ctrl2[C2_TRANSMIT_EMPTY_IRQ_EN]) | (receive_full_flag & ctrl2[C2_RECEIVE_FULL_IRQ_EN])
                 | (err_any & ctrl2[C2_ERROR_IRQ_EN]);
            TX_DMA_REQ <= transmit_empty_flag & ctrl2[C2_TXDMA] & port_en;
            RX_DMA_REQ <= receive_full_flag & ctrl2[C2_RXDMA];
        end
    end
endmodule

/* sim/spimsc_controller_asserts.sv */
`timescale 1ns/1ns
module spimsc_controller_asserts (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic PREADY,
    input wire logic [31:0] PRDATA,
    input wire logic PSLVERR,
    input wire spimsc_pkg::spimsc_pins_t PIN_OUT,
    input wire spimsc_pkg::spimsc_pins_t PIN_OE
);
    import spimsc_pkg::*;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    wire logic mapped;
    assign mapped = PADDR inside {ADDR_CTRL1, ADDR_CTRL2, ADDR_STAT, ADDR_DATA, ADDR_POLY,
        ADDR_RXCRC, ADDR_TXCRC, ADDR_HSCTL};

    property p_ready_after_setup;
        PSEL && !PENABLE |=> PREADY;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
    property p_ready_pulse;
        PREADY |=> !PREADY;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held two cycles");
    property p_err_map;
        PREADY |-> PSLVERR == !mapped;
    endproperty
    a_err_map: assert property (p_err_map) else $error("error response wrong for address");
    property p_upper_zero;
        PREADY |-> PRDATA[31:16] == 16'h0000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read half not zero");
    property p_write_zero;
        PREADY && PWRITE |-> PRDATA == 32'h00000000;
    endproperty
    a_write_zero: assert property (p_write_zero) else $error("read data on a write");
    property p_one_data_driver;
        !(PIN_OE.mosi && PIN_OE.miso);
    endproperty
    a_one_data_driver: assert property (p_one_data_driver) else $error("both data pins driven");
    property p_mosi_master;
        PIN_OE.mosi |-> PIN_OE.sck;
    endproperty
    a_mosi_master: assert property (p_mosi_master) else $error("out pin driven as slave");
    property p_slave_no_clock;
        PIN_OE.miso |-> !PIN_OE.sck;
    endproperty
    a_slave_no_clock: assert property (p_slave_no_clock) else $error("slave drives clock");
    property p_select_low;
        PIN_OE.nss |-> !PIN_OUT.nss && PIN_OE.sck;
    endproperty
    a_select_low: assert property (p_select_low) else $error("select driven high or as slave");
endmodule

bind spimsc_controller spimsc_controller_asserts chk (.CLOCK, .RESETN, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PREADY, .PRDATA, .PSLVERR, .PIN_OUT, .PIN_OE);

/* sim/spimsc_slave_model.sv */
`timescale 1ns/1ns
module spimsc_slave_model (
    input wire logic sck,
    input wire logic mosi,
    input wire logic go,
    input wire logic [7:0] load,
    output logic miso,
    output logic [7:0] got
);
    logic [7:0] tx = 8'h00;
    initial got = 8'h00;
    // Mode 0: capture on the rising edge, shift on the falling one
    always @(posedge sck) got <= {got[6:0], mosi};
    // Spent bits refill with a changing pattern, never a stale level
    always @(negedge sck or posedge go) begin
        if (go) tx <= load;
        else tx <= {tx[6:0], ~tx[7]};
    end
    assign miso = tx[7];
endmodule

/* sim/test_spi_master_slave_controller.sv */
`timescale 1ns/1ns
module test_spi_master_slave_controller;
    import spimsc_pkg::*;
    logic CLOCK = 1'b0;
    logic RESETN = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [31:0] PADDR = 32'h0;
    logic [31:0] PWDATA = 32'h0;
    logic PREADY, PSLVERR, IRQ, TX_DMA_REQ, RX_DMA_REQ;
    logic [31:0] PRDATA;
    spimsc_pins_t pin_in, pin_out, pin_oe;
    logic nss_ext = 1'b1;
    logic m_sck = 1'b0;
    logic m_mosi = 1'b0;
    logic m_on = 1'b0;
    logic tog = 1'b0;
    logic go = 1'b0;
    logic [7:0] load = 8'h00;
    logic s_miso;
    logic [7:0] got;
    logic [32:0] q[$];
    logic [32:0] e;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [31:0] addr_tab[9] = '{ADDR_CTRL1, ADDR_CTRL2, ADDR_STAT, ADDR_DATA, ADDR_POLY,
        ADDR_RXCRC, ADDR_TXCRC, ADDR_HSCTL, 32'h4001301c};
    logic [15:0] rst_tab[9] = '{RST_CTRL1, RST_CTRL2, 16'h0002, RST_WORD, RST_POLY, RST_WORD,
        RST_WORD, RST_HSCTL, 16'h0000};

    always #5 CLOCK = ~CLOCK;
    always @(posedge CLOCK) tog <= ~tog;
    // Released data line toggles so a stale level is never mistaken for data
    assign pin_in = '{sck: pin_oe.sck ? pin_out.sck : m_sck,
        mosi: pin_oe.mosi ? pin_out.mosi : m_on ? m_mosi : tog,
        miso: pin_oe.miso ? pin_out.miso : s_miso, nss: pin_oe.nss ? pin_out.nss : nss_ext};

    spimsc_controller dut (.CLOCK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY,
        .PRDATA, .PSLVERR, .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .IRQ,
        .TX_DMA_REQ, .RX_DMA_REQ);
    spimsc_slave_model slave (.sck(pin_in.sck), .mosi(pin_in.mosi), .go, .load,
        .miso(s_miso), .got);

    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
    endfunction

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task close_out;
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // For a read, d is the expected value under mask m
    task apb(input logic wr, input logic [31:0] a, input logic [15:0] d, input logic [15:0] m,
        input logic err);
        int k;
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= {16'h0000, d};
        if (!wr) q.push_back({err, m, d});
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        k = 0;
        do begin
            @(posedge CLOCK);
            k++;
        end while (PREADY !== 1'b1 && k < 20);
        if (PREADY !== 1'b1) begin
            n_mismatch++;
            close_out;
        end
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    always @(posedge CLOCK) begin
        if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
            e = q.pop_front();
            chk(PRDATA & {16'hffff, e[31:16]}, {16'h0000, e[15:0]});
            chk({31'h0, PSLVERR}, {31'h0, e[32]});
        end
    end

    task wait_for(input logic use_irq, input logic lvl);
        int k;
        k = 0;
        while ((use_irq ? IRQ : RX_DMA_REQ) !== lvl && k < 4000) begin
            @(posedge CLOCK);
            k++;
        end
        if (k >= 4000) begin
            n_mismatch++;
            close_out;
        end
    endtask

    // Starts one byte and measures one serial clock period
    task xfer(input logic [15:0] c1, input logic [7:0] tx, input logic [7:0] sl, input int div);
        int c;
        apb(1'b1, ADDR_CTRL1, c1, 16'h0, 1'b0);
        load <= sl;
        go <= 1'b1;
        @(posedge CLOCK);
        go <= 1'b0;
        apb(1'b1, ADDR_DATA, {8'h00, tx}, 16'h0, 1'b0);
        c = 0;
        while (pin_in.sck !== 1'b1 && c < 3000) begin
            @(posedge CLOCK);
            c++;
        end
        if (c >= 3000) begin
            n_mismatch++;
            close_out;
        end
        c = 0;
        while (pin_in.sck === 1'b1 && c < 600) begin
            @(posedge CLOCK);
            c++;
        end
        while (pin_in.sck !== 1'b1 && c < 600) begin
            @(posedge CLOCK);
            c++;
        end
        if (c >= 600) begin
            n_mismatch++;
            close_out;
        end
        chk(32'(c), 32'(div));
    endtask

    initial begin
        logic [7:0] tx, sl, sa;
        logic [15:0] c1, pv;
        logic [2:0] br;
        int div;
        void'($urandom(32'h555fd84c));
        repeat (4) @(posedge CLOCK);
        RESETN <= 1'b1;
        for (int i = 0; i < 9; i++) apb(1'b0, addr_tab[i], rst_tab[i], 16'hffff, i == 8);
        $display("Reset values done");
        apb(1'b1, ADDR_CTRL2, 16'hffff, 16'h0, 1'b0);
        apb(1'b0, ADDR_CTRL2, MASK_CTRL2, 16'hffff, 1'b0);
        apb(1'b1, ADDR_HSCTL, 16'hffff, 16'h0, 1'b0);
        apb(1'b0, ADDR_HSCTL, MASK_HSCTL, 16'hffff, 1'b0);
        pv = 16'($urandom);
        apb(1'b1, ADDR_POLY, pv, 16'h0, 1'b0);
        apb(1'b0, ADDR_POLY, pv, 16'hffff, 1'b0);
        $display("Register access done");
        apb(1'b1, ADDR_CTRL2, 16'h0043, 16'h0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            br = 3'($urandom % 3);
            tx = 8'($urandom);
            sl = 8'($urandom);
            div = i[1] ? int'(br) + 2 : 2 << int'(br);
            apb(1'b1, ADDR_HSCTL, {15'h0, i[1]}, 16'h0, 1'b0);
            c1 = 16'h0344 | {8'h00, i[0], 7'h00} | {10'h000, br, 3'h0};
            xfer(c1, tx, sl, div);
            wait_for(1'b1, 1'b1);
            chk({24'h0, got}, {24'h0, i[0] ? rev(tx) : tx});
            chk({31'h0, TX_DMA_REQ}, 32'h1);
            apb(1'b0, ADDR_DATA, {8'h00, i[0] ? rev(sl) : sl}, 16'hffff, 1'b0);
            wait_for(1'b1, 1'b0);
        end
        $display("Transfers done");
        apb(1'b1, ADDR_HSCTL, 16'h0, 16'h0, 1'b0);
        // Select output on, hardware select: the pin must stay low through the word
        apb(1'b1, ADDR_CTRL2, 16'h0025, 16'h0, 1'b0);
        sa = 8'($urandom);
        xfer(16'h0044, 8'($urandom), sa, 2);
        chk({31'h0, pin_in.nss}, 32'h0);
        wait_for(1'b0, 1'b1);
        xfer(16'h0044, 8'($urandom), 8'($urandom), 2);
        wait_for(1'b1, 1'b1);
        apb(1'b0, ADDR_STAT, 16'h0041, 16'h0041, 1'b0);
        // A status read alone must not clear the overrun
        apb(1'b0, ADDR_STAT, 16'h0040, 16'h0040, 1'b0);
        apb(1'b0, ADDR_DATA, {8'h00, sa}, 16'hffff, 1'b0);
        apb(1'b0, ADDR_STAT, 16'h0000, 16'h0001, 1'b0);
        apb(1'b0, ADDR_STAT, 16'h0000, 16'h0041, 1'b0);
        wait_for(1'b1, 1'b0);
        $display("Overrun done");
        apb(1'b1, ADDR_CTRL1, 16'h0, 16'h0, 1'b0);
        apb(1'b1, ADDR_CTRL2, 16'h0020, 16'h0, 1'b0);
        apb(1'b1, ADDR_CTRL1, 16'h0044, 16'h0, 1'b0);
        nss_ext <= 1'b0;
        wait_for(1'b1, 1'b1);
        apb(1'b0, ADDR_STAT, 16'h0020, 16'h0020, 1'b0);
        apb(1'b0, ADDR_CTRL1, 16'h0000, 16'hffff, 1'b0);
        nss_ext <= 1'b1;
        apb(1'b1, ADDR_CTRL1, 16'h0, 16'h0, 1'b0);
        apb(1'b0, ADDR_STAT, 16'h0000, 16'h0020, 1'b0);
        wait_for(1'b1, 1'b0);
        $display("Mode fault done");
        tx = 8'($urandom);
        sl = 8'($urandom);
        apb(1'b1, ADDR_CTRL2, 16'h0040, 16'h0, 1'b0);
        apb(1'b1, ADDR_DATA, {8'h00, tx}, 16'h0, 1'b0);
        // Far master keeps the select low through the soft level bit left clear
        apb(1'b1, ADDR_CTRL1, 16'h0240, 16'h0, 1'b0);
        m_on <= 1'b1;
        // Bench plays the far master: slow clock, slave output taken before each rise
        for (int b = 7; b >= 0; b--) begin
            m_mosi <= sl[b];
            repeat (4) @(posedge CLOCK);
            sa[b] = pin_in.miso;
            m_sck <= 1'b1;
            repeat (4) @(posedge CLOCK);
            m_sck <= 1'b0;
        end
        wait_for(1'b1, 1'b1);
        chk({24'h0, sa}, {24'h0, tx});
        apb(1'b0, ADDR_DATA, {8'h00, sl}, 16'hffff, 1'b0);
        apb(1'b1, ADDR_CTRL1, 16'h0, 16'h0, 1'b0);
        m_on <= 1'b0;
        wait_for(1'b1, 1'b0);
        $display("Slave done");
        close_out;
    end
endmodule
